// ===== cpu_shift_flag_sleep_unit.sv
// Execution unit for single and multi-bit shifts, set-flag and power-down.
// Assumes decode presents one instruction per cycle with issueValid and
// reads the register file combinationally through readData.
//
// Summary of operation
// RULE1 - Set-flag forces the condition flag to one and advances PC by two.
// RULE2 - Set-flag is the fixed pattern 0x0018 and completes in one cycle.
// RULE3 - Left one-bit shifts move bit 31 to the flag, fill zero, one cycle.
// RULE4 - Arithmetic right shift moves bit 0 to the flag and keeps bit 31.
// RULE5 - Logical right shift moves bit 0 to the flag and clears bit 31.
// RULE6 - Left shifts by 2, 8, 16 zero-fill and leave the flag alone.
// RULE7 - Right shifts by 2, 8, 16 zero-fill and leave the flag alone.
// RULE8 - Power-down takes three cycles to reach the low-power state.
// RULE9 - In low power no instruction issues and all state is held.
// RULE10 - An interrupt request ends low power and starts exception handling.
// RULE11 - Bits 11 to 8 of a shift select the source and destination register.
`include "cpu_shift_flag_sleep_cfg.svh"
`timescale 1ns/100ps

module cpu_shift_flag_sleep_unit
    import cpu_shift_flag_sleep_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int SEL_W  = 4
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              issueValid,
    input  wire logic [15:0]       instrWord,
    input  wire logic [DATA_W-1:0] pcIn,
    input  wire logic [DATA_W-1:0] readData,
    input  wire logic              irqRequest,
    output logic [SEL_W-1:0]       readSel,
    output logic                   issueReady,
    output logic                   writeEnable,
    output logic [SEL_W-1:0]       writeSel,
    output logic [DATA_W-1:0]      writeData,
    output logic                   flagOut,
    output logic                   pcValid,
    output logic [DATA_W-1:0]      pcOut,
    output logic                   sleeping,
    output logic                   exceptionStart
);

    // ======================================================================
    // Decode
    function automatic op_t decode_op(input logic [15:0] w);
        op_t op;
        op = OP_NONE;
        if (w == `SET_FLAG_CODE) begin
            op = OP_SET_FLAG;                               // [RULE2]
        end else if (w == `POWER_DOWN_CODE) begin
            op = OP_POWER_DOWN;
        end else if (w[15:12] == `SHIFT_GROUP_HI) begin
            unique case (w[7:0])
                `ARITH_LEFT_ONE_LO,
                `LOGICAL_LEFT_ONE_LO:      op = OP_LEFT_ONE;
                `ARITH_RIGHT_ONE_LO:       op = OP_ARITH_RIGHT_ONE;
                `LOGICAL_RIGHT_ONE_LO:     op = OP_LOGICAL_RIGHT_ONE;
                `LOGICAL_LEFT_TWO_LO:      op = OP_LEFT_TWO;
                `LOGICAL_LEFT_EIGHT_LO:    op = OP_LEFT_EIGHT;
                `LOGICAL_LEFT_SIXTEEN_LO:  op = OP_LEFT_SIXTEEN;
                `LOGICAL_RIGHT_TWO_LO:     op = OP_RIGHT_TWO;
                `LOGICAL_RIGHT_EIGHT_LO:   op = OP_RIGHT_EIGHT;
                `LOGICAL_RIGHT_SIXTEEN_LO: op = OP_RIGHT_SIXTEEN;
                default:                   op = OP_NONE;
            endcase
        end
        return op;
    endfunction : decode_op

    op_t              curOp;
    state_t           state_reg;
    logic [1:0]       enterCount_reg;
    logic             flag_reg;
    logic             accept;
    logic [DATA_W-1:0] shifted;
    logic             shiftFlag;
    logic             isShift;
    logic             flagTouched;

    assign curOp  = decode_op(instrWord);
    assign accept = issueValid && (state_reg == ST_RUN);          // [RULE9]
    assign readSel = instrWord[`REG_SEL_MSB:`REG_SEL_LSB];        // [RULE11]

    // ======================================================================
    // Shifter
    always_comb begin
        shifted     = readData;
        shiftFlag   = flag_reg;
        isShift     = 1'b1;
        flagTouched = 1'b0;
        unique case (curOp)
            OP_LEFT_ONE: begin
                shifted     = {readData[DATA_W-2:0], 1'b0};       // [RULE3]
                shiftFlag   = readData[DATA_W-1];
                flagTouched = 1'b1;
            end
            OP_ARITH_RIGHT_ONE: begin
                shifted     = {readData[DATA_W-1],
                               readData[DATA_W-1:1]};             // [RULE4]
                shiftFlag   = readData[0];
                flagTouched = 1'b1;
            end
            OP_LOGICAL_RIGHT_ONE: begin
                shifted     = {1'b0, readData[DATA_W-1:1]};       // [RULE5]
                shiftFlag   = readData[0];
                flagTouched = 1'b1;
            end
            OP_LEFT_TWO:      shifted = readData << 2;            // [RULE6]
            OP_LEFT_EIGHT:    shifted = readData << 8;            // [RULE6]
            OP_LEFT_SIXTEEN:  shifted = readData << 16;           // [RULE6]
            OP_RIGHT_TWO:     shifted = readData >> 2;            // [RULE7]
            OP_RIGHT_EIGHT:   shifted = readData >> 8;            // [RULE7]
            OP_RIGHT_SIXTEEN: shifted = readData >> 16;           // [RULE7]
            OP_SET_FLAG: begin
                isShift     = 1'b0;
                shiftFlag   = 1'b1;                               // [RULE1]
                flagTouched = 1'b1;
            end
            default:          isShift = 1'b0;
        endcase
    end

    // ======================================================================
    // Register writeback, one cycle per shift
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            writeEnable <= 1'b0;
            writeSel    <= '0;
            writeData   <= '0;
        end else begin
            writeEnable <= accept && isShift;                     // [RULE11]
            if (accept) begin
                writeSel  <= instrWord[`REG_SEL_MSB:`REG_SEL_LSB];
                writeData <= shifted;                             // [RULE9]
            end
        end
    end

    // ======================================================================
    // Condition flag
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            flag_reg <= `FLAG_RESET;
        end else if (accept && flagTouched) begin
            flag_reg <= shiftFlag;                                // [RULE1]
        end
    end
    assign flagOut = flag_reg;

    // ======================================================================
    // Program counter
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pcValid <= 1'b0;
            pcOut   <= '0;
        end else begin
            pcValid <= accept && (curOp != OP_NONE);
            if (accept) begin
                if (curOp == OP_POWER_DOWN) begin
                    pcOut <= pcIn;
                end else begin
                    pcOut <= pcIn + `PC_STEP;                     // [RULE1]
                end
            end
        end
    end

    // ======================================================================
    // Power-down sequencing
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg      <= ST_RUN;
            enterCount_reg <= 2'h0;
            sleeping       <= 1'b0;
            issueReady     <= 1'b1;
            exceptionStart <= 1'b0;
        end else begin
            exceptionStart <= 1'b0;
            unique case (state_reg)
                ST_RUN: begin
                    if (accept && curOp == OP_POWER_DOWN) begin
                        state_reg      <= ST_ENTER;               // [RULE8]
                        enterCount_reg <= 2'h1;
                        issueReady     <= 1'b0;
                    end
                end
                ST_ENTER: begin
                    if (enterCount_reg == `POWER_DOWN_CYCLES - 2'h1) begin
                        state_reg <= ST_SLEEP;                    // [RULE8]
                        sleeping  <= 1'b1;
                    end else begin
                        enterCount_reg <= enterCount_reg + 2'h1;
                    end
                end
                ST_SLEEP: begin
                    if (irqRequest) begin
                        state_reg      <= ST_RUN;                 // [RULE10]
                        sleeping       <= 1'b0;
                        issueReady     <= 1'b1;
                        exceptionStart <= 1'b1;
                    end
                end
                default: begin
                    state_reg  <= ST_RUN;
                    sleeping   <= 1'b0;
                    issueReady <= 1'b1;
                end
            endcase
        end
    end
    // Nothing issues while issueReady is low, so all state holds [RULE9]

endmodule : cpu_shift_flag_sleep_unit

// ===== cpu_shift_flag_sleep_cfg.svh
// Constants for the shift, set-flag and power-down execution unit.
// Assumes a 16-bit instruction word and a 32-bit general register file.
`ifndef CPU_SHIFT_FLAG_SLEEP_CFG_SVH
`define CPU_SHIFT_FLAG_SLEEP_CFG_SVH

// ==========================================================================
// Encodings
`define SET_FLAG_CODE       16'h0018
`define POWER_DOWN_CODE     16'h001b
`define SHIFT_GROUP_HI      4'h4
`define ARITH_LEFT_ONE_LO   8'h20
`define LOGICAL_LEFT_ONE_LO 8'h00
`define ARITH_RIGHT_ONE_LO  8'h21
`define LOGICAL_RIGHT_ONE_LO 8'h01
`define LOGICAL_LEFT_TWO_LO 8'h08
`define LOGICAL_LEFT_EIGHT_LO 8'h18
`define LOGICAL_LEFT_SIXTEEN_LO 8'h28
`define LOGICAL_RIGHT_TWO_LO 8'h09
`define LOGICAL_RIGHT_EIGHT_LO 8'h19
`define LOGICAL_RIGHT_SIXTEEN_LO 8'h29

// ==========================================================================
// Fields, timing and reset values
`define REG_SEL_MSB         11
`define REG_SEL_LSB         8
`define POWER_DOWN_CYCLES   2'h3
`define PC_STEP             32'h0000_0002
`define FLAG_RESET          1'h0

`endif

// ===== cpu_shift_flag_sleep_pkg.sv
// Types for the shift, set-flag and power-down execution unit.
// Assumes the constants header is included by the design file.
package cpu_shift_flag_sleep_pkg;

    // ======================================================================
    // Decoded operations
    typedef enum logic [3:0] {
        OP_NONE,
        OP_SET_FLAG,
        OP_POWER_DOWN,
        OP_LEFT_ONE,
        OP_ARITH_RIGHT_ONE,
        OP_LOGICAL_RIGHT_ONE,
        OP_LEFT_TWO,
        OP_LEFT_EIGHT,
        OP_LEFT_SIXTEEN,
        OP_RIGHT_TWO,
        OP_RIGHT_EIGHT,
        OP_RIGHT_SIXTEEN
    } op_t;

    // ======================================================================
    // Execution states
    typedef enum logic [1:0] {
        ST_RUN,
        ST_ENTER,
        ST_SLEEP
    } state_t;

endpackage : cpu_shift_flag_sleep_pkg

// ===== reg_file_model.sv
// Register file model facing the unit.
// Assumes a combinational read port and one write port on clk_sys.
`timescale 1ns/100ps

// ==========================================================================
// Register file
module reg_file_model (
    input  wire logic        clk_sys,
    input  wire logic [3:0]  readSel,
    input  wire logic        writeEnable,
    input  wire logic [3:0]  writeSel,
    input  wire logic [31:0] writeData,
    output logic      [31:0] readData
);
    logic [31:0] regs [16];
    assign readData = regs[readSel];
    always @(posedge clk_sys) begin
        if (writeEnable) regs[writeSel] <= writeData;
    end
endmodule : reg_file_model

// ===== cpu_shift_flag_sleep_checker.sv
// Checker for the shift, set-flag and power-down unit.
// Assumes default widths of the unit.
`include "cpu_shift_flag_sleep_cfg.svh"
`timescale 1ns/100ps

// ==========================================================================
// Checker
module cpu_shift_flag_sleep_checker (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        issueValid,
    input wire logic [15:0] instrWord,
    input wire logic [31:0] pcIn,
    input wire logic [31:0] readData,
    input wire logic        irqRequest,
    input wire logic [3:0]  readSel,
    input wire logic        issueReady,
    input wire logic        writeEnable,
    input wire logic [3:0]  writeSel,
    input wire logic [31:0] writeData,
    input wire logic        flagOut,
    input wire logic        pcValid,
    input wire logic [31:0] pcOut,
    input wire logic        sleeping,
    input wire logic        exceptionStart
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [31:0] rdQ, pcQ;
    logic [3:0]  selQ;
    logic        tk, sh;
    logic [7:0]  lo;
    assign tk = issueValid && issueReady;
    assign lo = instrWord[7:0];
    assign sh = tk && instrWord[15:12] == `SHIFT_GROUP_HI;
    always_ff @(posedge clk_sys) begin
        rdQ  <= readData;
        pcQ  <= pcIn;
        selQ <= readSel;
    end
    set_flag_a: assert property (tk && instrWord == `SET_FLAG_CODE
        |=> flagOut && pcValid && pcOut == pcQ + 32'h2) else $error("set flag");
    left_one_a: assert property (sh && (lo == `ARITH_LEFT_ONE_LO
        || lo == `LOGICAL_LEFT_ONE_LO) |=> writeEnable && flagOut == rdQ[31]
        && writeData == {rdQ[30:0], 1'b0}) else $error("left one");
    arith_right_a: assert property (sh && lo == `ARITH_RIGHT_ONE_LO
        |=> flagOut == rdQ[0] && writeData == {rdQ[31], rdQ[31:1]})
        else $error("arith right");
    logic_right_a: assert property (sh && lo == `LOGICAL_RIGHT_ONE_LO
        |=> flagOut == rdQ[0] && writeData == {1'b0, rdQ[31:1]}
        && writeSel == selQ) else $error("logic right");
    multi_flag_a: assert property (sh && lo[7:6] == 2'h0
        && lo[5:4] != 2'h3 && lo[3:1] == 3'h4 |=> writeEnable
        && $stable(flagOut)) else $error("multi shift flag");
    enter_sleep_a: assert property (tk && instrWord == `POWER_DOWN_CODE
        |=> !issueReady && !sleeping ##1 !sleeping ##1 sleeping)
        else $error("sleep entry");
    sleep_hold_a: assert property (sleeping && !irqRequest
        |=> !writeEnable && !pcValid && !issueReady && $stable(flagOut)
        && $stable(writeData) && $stable(pcOut))
        else $error("sleep hold");
    wake_a: assert property (sleeping && irqRequest
        |=> exceptionStart && !sleeping && issueReady) else $error("wake");
endmodule : cpu_shift_flag_sleep_checker

bind cpu_shift_flag_sleep_unit cpu_shift_flag_sleep_checker
    cpu_shift_flag_sleep_checker_inst (.*);

// ===== tb_top.sv
// Testbench for the shift, set-flag and power-down unit.
// Assumes the register file model and the bound checker.
`include "cpu_shift_flag_sleep_cfg.svh"
`timescale 1ns/100ps

// ==========================================================================
// Testbench
module tb_top;
    logic        clk_sys, reset, issueValid, irqRequest, issueReady;
    logic        writeEnable, flagOut, pcValid, sleeping, exceptionStart;
    logic [15:0] instrWord;
    logic [31:0] pcIn, readData, writeData, pcOut;
    logic [3:0]  readSel, writeSel;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    cpu_shift_flag_sleep_unit cpu_shift_flag_sleep_unit_inst (.*);
    reg_file_model reg_file_model_inst (.*);
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task step;
        @(posedge clk_sys);
        #1;
    endtask : step
    task issue(input logic [15:0] w);
        issueValid = 1'h1;
        instrWord = w;
        step();
        issueValid = 1'h0;
    endtask : issue
    task one(input logic [7:0] lo, input logic [3:0] rg,
             input logic [31:0] v, input logic [31:0] e, input logic f);
        reg_file_model_inst.regs[rg] = v;
        issue({`SHIFT_GROUP_HI, rg, lo});
        chk(writeEnable, 32'h1);
        chk(writeSel, rg);
        chk(writeData, e);
        chk(flagOut, f);
        chk(pcOut, 32'h1002);
        step();
    endtask : one
    task t_single;
        one(`ARITH_LEFT_ONE_LO, 4'h1, 32'h80000001, 32'h2, 1);
        one(`LOGICAL_LEFT_ONE_LO, 4'h2, 32'h40000000, 32'h80000000, 0);
        one(`ARITH_RIGHT_ONE_LO, 4'h3, 32'h80000001, 32'hc0000000, 1);
        one(`LOGICAL_RIGHT_ONE_LO, 4'hf, 32'h80000001, 32'h40000000, 1);
        one(`LOGICAL_RIGHT_ONE_LO, 4'h0, 32'hfffffffe, 32'h7fffffff, 0);
        $display("single shifts done");
    endtask : t_single
    task t_multi;
        one(`LOGICAL_LEFT_TWO_LO, 4'h5, 32'h12345678, 32'h48d159e0, 0);
        one(`LOGICAL_LEFT_EIGHT_LO, 4'h6, 32'h12345678, 32'h34567800, 0);
        one(`LOGICAL_LEFT_SIXTEEN_LO, 4'h7, 32'h12345678, 32'h56780000, 0);
        one(`LOGICAL_RIGHT_TWO_LO, 4'h8, 32'h12345678, 32'h048d159e, 0);
        one(`LOGICAL_RIGHT_EIGHT_LO, 4'h9, 32'h12345678, 32'h00123456, 0);
        one(`LOGICAL_RIGHT_SIXTEEN_LO, 4'ha, 32'h12345678, 32'h1234, 0);
        $display("multi shifts done");
    endtask : t_multi
    task t_set_flag;
        issue(`SET_FLAG_CODE);
        chk(flagOut, 32'h1);
        chk(pcValid, 32'h1);
        chk(pcOut, 32'h1002);
        step();
        issue(16'hffff);
        chk(writeEnable, 32'h0);
        chk(pcValid, 32'h0);
        step();
        one(`LOGICAL_RIGHT_TWO_LO, 4'hb, 32'hff, 32'h3f, 1);
        $display("set flag done");
    endtask : t_set_flag
    task t_sleep;
        one(`LOGICAL_RIGHT_ONE_LO, 4'hc, 32'h2, 32'h1, 0);
        issue(`POWER_DOWN_CODE);
        chk(issueReady, 32'h0);
        step();
        chk(sleeping, 32'h0);
        step();
        chk(sleeping, 32'h1);
        issueValid = 1'h1;
        instrWord = `SET_FLAG_CODE;
        repeat (3) step();
        chk(flagOut, 32'h0);
        chk(pcValid, 32'h0);
        chk(sleeping, 32'h1);
        issueValid = 1'h0;
        irqRequest = 1'h1;
        step();
        chk(exceptionStart, 32'h1);
        chk(sleeping, 32'h0);
        chk(issueReady, 32'h1);
        irqRequest = 1'h0;
        step();
        $display("sleep done");
    endtask : t_sleep
    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        reset = 1'h1;
        issueValid = 1'h0;
        irqRequest = 1'h0;
        instrWord = 16'h0;
        pcIn = 32'h1000;
        repeat (12) @(posedge clk_sys);
        #1;
        reset = 1'h0;
        t_single();
        t_multi();
        t_set_flag();
        t_sleep();
        conclude();
    end
endmodule : tb_top
